// >>> bench/adsfe_far_model.sv
`timescale 1ns/1ps
module adsfe_far_model (
  input  wire logic i_clk,    // System clock
  output logic      o_bck,    // Bit clock
  output logic      o_word_select_clock,   // Word select
  output logic      o_sdata,  // Audio data
  output logic      o_cs_n,   // Control select
  output logic      o_cclk,   // Control clock
  output logic      o_cdin    // Control data
);
  initial begin
    o_bck   = 1'b0;
    o_word_select_clock  = 1'b1;
    o_sdata = 1'b0;
    o_cs_n  = 1'b1;
    o_cclk  = 1'b0;
    o_cdin  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // Data moves while the bit clock is low
  task automatic abit(input logic b);
    o_sdata <= b;
    tick(2);
    o_bck <= 1'b1;
    tick(2);
    o_bck <= 1'b0;
  endtask : abit
  // Two slots of nb bit clocks, MSB first
  task automatic frame(input bit i2s, input int nb, input logic [23:0] l,
                       input logic [23:0] r);
    logic [63:0] w;
    w = i2s ? {1'b0, l, 8'h00, r, 7'h00} : {l, 8'h00, r, 8'h00};
    @(posedge i_clk);
    o_word_select_clock <= ~i2s;
    for (int h = 0; h < 2; h++) begin
      for (int i = 0; i < nb; i++) begin
        abit(w[63 - 32 * h - i]);
      end
      o_word_select_clock <= (h == 0) ? i2s : ~i2s;
    end
    o_sdata <= ~o_sdata;
  endtask : frame
  // Control word, shorter frames on request
  task automatic cwrite(input logic [15:0] w, input int nb);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      o_cdin <= w[15 - i];
      tick(2);
      o_cclk <= 1'b1;
      tick(2);
      o_cclk <= 1'b0;
    end
    o_cs_n <= 1'b1;
    o_cdin <= ~o_cdin;
    tick(6);
  endtask : cwrite
endmodule : adsfe_far_model

// >>> bench/audio_dac_serial_front_end_test.sv
`timescale 1ns/1ps
module audio_dac_serial_front_end_test;
  localparam int HOLD = 16;
  localparam int RAMP = 4;
  localparam int MBH  = 4;
  logic                     i_clk, i_rst, i_pd_n, i_fmt_pin, i_deemphasis_pin_pin, i_analog_mix_enable_pin;
  logic                     f_bck, f_word_select_clock, f_sdata, f_cs_n, f_cclk, f_cdin;
  logic                     o_bck, o_bck_oe, o_word_select_clock, o_word_select_clock_oe, o_sample_valid, o_halted;
  logic                     bck_w, word_select_clock_w, av_rd, av_wr, o_avs_waitrequest;
  adsfe_pkg::adsfe_sample_t o_sample, last_smp;
  adsfe_pkg::adsfe_cfg_t    o_cfg;
  logic [13:0]              o_ramp_level;
  logic [3:0]               av_addr;
  logic [31:0]              av_wdata, o_avs_readdata, rd;
  int                       n_errors, tests_run, n;
  int                       cyc = 0;

  assign bck_w  = o_bck_oe ? o_bck : f_bck;
  assign word_select_clock_w = o_word_select_clock_oe ? o_word_select_clock : f_word_select_clock;

  adsfe_far_model adsfe_far_model_inst (.i_clk(i_clk), .o_bck(f_bck), .o_word_select_clock(f_word_select_clock),
    .o_sdata(f_sdata), .o_cs_n(f_cs_n), .o_cclk(f_cclk), .o_cdin(f_cdin));

  adsfe_top #(.HOLD_CYC(HOLD), .RAMP_FS(RAMP), .MBCK_HALF(MBH)) adsfe_top_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_pd_n(i_pd_n), .i_bck(bck_w), .i_word_select_clock(word_select_clock_w),
    .i_sdata(f_sdata), .i_cs_n(f_cs_n), .i_cclk(f_cclk), .i_cdin(f_cdin),
    .i_fmt_pin(i_fmt_pin), .i_deemphasis_pin_pin(i_deemphasis_pin_pin), .i_analog_mix_enable_pin(i_analog_mix_enable_pin),
    .o_bck(o_bck), .o_bck_oe(o_bck_oe), .o_word_select_clock(o_word_select_clock), .o_word_select_clock_oe(o_word_select_clock_oe),
    .o_sample(o_sample), .o_sample_valid(o_sample_valid), .o_cfg(o_cfg),
    .o_ramp_level(o_ramp_level), .o_halted(o_halted), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_byteenable(4'hF),
    .i_avs_writedata(av_wdata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_sample_valid === 1'b1) begin
      last_smp <= o_sample;
    end
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is seen low
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    av_rd    <= ~wr;
    av_wr    <= wr;
    av_addr  <= a;
    av_wdata <= d;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 50);
    rd = o_avs_readdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    check(k >= 50, 1'b0);
  endtask : av_xfer

  task automatic run(input bit i2s, input int k, input int nb, input logic [23:0] l,
                     input logic [23:0] r);
    repeat (k) adsfe_far_model_inst.frame(i2s, nb, l, r);
    repeat (8) @(posedge i_clk);
  endtask : run

  task automatic meas(input bit lr, output int cnt);
    logic prev, cur;
    int   st;
    cnt  = 0;
    st   = 0;
    prev = 1'b1;
    while (st < 2 && cnt < 2000) begin
      @(posedge i_clk);
      cur = lr ? o_word_select_clock : o_bck;
      if (cur === 1'b1 && prev === 1'b0) st++;
      if (st == 1) cnt++;
      prev = cur;
    end
  endtask : meas

  task automatic t_boot();
    @(posedge i_clk);
    i_pd_n <= 1'b1;
    repeat (HOLD - 6) @(posedge i_clk);
    av_xfer(1'b0, 4'h0, 32'h0);
    check(rd[0], 1'b1);
    repeat (12) @(posedge i_clk);
    av_xfer(1'b0, 4'h0, 32'h0);
    check(rd[0], 1'b0);
    av_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h00003F3F);
    check({o_bck_oe, o_word_select_clock_oe}, 2'b00);
  endtask : t_boot

  task automatic t_ctrl();
    logic [15:0] bad [3];
    bad = '{16'h0205, 16'h8205, 16'h0505};
    for (int i = 0; i < 3; i++) begin
      adsfe_far_model_inst.cwrite(bad[i], (i == 0) ? 15 : 16);
    end
    adsfe_far_model_inst.cwrite(16'h0112, 16);
    adsfe_far_model_inst.cwrite(16'h0221, 16);
    av_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h00002112);
    check({o_cfg.mutl, o_cfg.mutr, o_cfg.atl, o_cfg.atr}, {2'b00, 6'h12, 6'h21});
  endtask : t_ctrl

  task automatic t_audio();
    run(1'b0, 6, 32, 24'h812345, 24'h7EDCBA);
    check(last_smp, 48'h8123457EDCBA);
    check(o_ramp_level, 14'(RAMP));
    av_xfer(1'b0, 4'h0, 32'h0);
    check(rd[4:3], 2'd2);
    run(1'b0, 1, 24, 24'h000000, 24'h000000);
    check(o_halted, 1'b1);
    run(1'b0, 4, 32, 24'h00F00F, 24'hFFFFFF);
    check({o_halted, last_smp}, {1'b0, 48'h00F00FFFFFFF});
    adsfe_far_model_inst.cwrite(16'h0301, 16);
    run(1'b1, 6, 32, 24'hA5A5A5, 24'h5A5A5A);
    check(last_smp, 48'hA5A5A55A5A5A);
  endtask : t_audio

  task automatic t_pins();
    av_xfer(1'b1, 4'h8, 32'h1);
    av_xfer(1'b0, 4'h8, 32'h0);
    check(rd[0], 1'b1);
    i_deemphasis_pin_pin <= 1'b1;
    i_analog_mix_enable_pin <= 1'b1;
    repeat (8) @(posedge i_clk);
    check({o_cfg.deemph, o_cfg.analog_mix_enable}, 2'b11);
    i_deemphasis_pin_pin <= 1'b0;
    i_analog_mix_enable_pin <= 1'b0;
    repeat (8) @(posedge i_clk);
    check({o_cfg.deemph, o_cfg.analog_mix_enable}, 2'b00);
    av_xfer(1'b1, 4'h8, 32'h0);
  endtask : t_pins

  task automatic t_master();
    adsfe_far_model_inst.cwrite(16'h0305, 16);
    check({o_bck_oe, o_word_select_clock_oe}, 2'b11);
    meas(1'b0, n);
    check(n, 2 * MBH);
    meas(1'b1, n);
    check(n, 128 * MBH);
    adsfe_far_model_inst.cwrite(16'h0300, 16);
    check({o_bck_oe, o_word_select_clock_oe}, 2'b00);
  endtask : t_master

  task automatic t_power();
    run(1'b0, 4, 32, 24'hA5A5A5, 24'h5A5A5A);
    check(last_smp, 48'hA5A5A55A5A5A);
    adsfe_far_model_inst.cwrite(16'h0401, 16);
    av_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h01002112);
    run(1'b0, 2, 32, 24'h111111, 24'h222222);
    check(last_smp, 48'hA5A5A55A5A5A);
    adsfe_far_model_inst.cwrite(16'h0400, 16);
    i_pd_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    av_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h00003F3F);
    i_pd_n <= 1'b1;
    repeat (HOLD + 8) @(posedge i_clk);
    adsfe_far_model_inst.cwrite(16'h0105, 16);
    av_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h00003F05);
  endtask : t_power

  initial begin
    i_rst      = 1'b1;
    i_pd_n     = 1'b0;
    i_fmt_pin  = 1'b0;
    i_deemphasis_pin_pin = 1'b0;
    i_analog_mix_enable_pin = 1'b0;
    av_rd      = 1'b0;
    av_wr      = 1'b0;
    av_addr    = 4'h0;
    av_wdata   = 32'h0;
    n_errors   = 0;
    tests_run  = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_boot();
    t_ctrl();
    t_audio();
    t_pins();
    t_master();
    t_power();
    wrap_up();
  end
endmodule : audio_dac_serial_front_end_test

// >>> hw/adsfe_top.sv
`timescale 1ns/1ps
`include "adsfe_consts.svh"
// Summary of operation
// R1 - Power-down pin low resets all digital logic and the mode registers; the output ramp and master clock generator are not reset.
// R2 - Software power-down bit resets logic but keeps mode registers.
// R3 - Pin or software power changes use the same output ramp sequence.
// R4 - Logic held in reset 1024 clocks after power-down pin rises.
// R5 - Output ramps over 9334 sample periods, up and down.
// R6 - Serial audio data sampled on each bit clock rising edge.
// R7 - Word-select edge stores the sample; its level names the channel.
// R8 - Format field picks master (clocks driven) or slave (clocks input).
// R9 - Format 000 left-justified slave, 001 I2S, 101 left-justified master.
// R10 - Slave source gives fs word select and 32/48/64 fs bit clock.
// R11 - Slave source should derive its clocks from the system clock.
// R12 - Master mode drives word select at fs, bit clock at 64 fs.
// R13 - Any phase between word select and system clock is accepted.
// R14 - Drift over 3 bit clocks per period halts and holds output.
// R15 - Reset default is 24-bit left-justified slave.
// R16 - Samples are two's complement, MSB first.
// R17 - Right-justified, I2S, left-justified; 16, 20 or 24 bits.
// R18 - Pin variant: format pin low left-justified, high I2S.
// R19 - Pin variant: de-emphasis and mixing pins enable when high.
// R20 - Control port runs apart from audio and only writes mode registers.
// R21 - Control word: zero, seven-bit index, eight data bits.
// R22 - Control data shifted on control clock rising edges.
// R23 - Host holds select low and raises it after the last bit.
// R24 - Host may keep control clock running while select is low.
// R25 - Commit on select rise; frames under 16 bits are dropped.
module adsfe_top #(
  parameter int HOLD_CYC  = `ADSFE_HOLD_CYC,
  parameter int RAMP_FS   = `ADSFE_RAMP_FS,
  parameter int MBCK_HALF = `ADSFE_MBCK_CYC
) (
  input  wire logic                    i_clk,             // System clock
  input  wire logic                    i_rst,             // Async reset
  input  wire logic                    i_pd_n,            // Power-down pin
  input  wire logic                    i_bck,             // Bit clock in
  input  wire logic                    i_word_select_clock,            // Word select in
  input  wire logic                    i_sdata,           // Serial audio
  input  wire logic                    i_cs_n,            // Control select
  input  wire logic                    i_cclk,            // Control clock
  input  wire logic                    i_cdin,            // Control data
  input  wire logic                    i_fmt_pin,         // Pin format
  input  wire logic                    i_deemphasis_pin_pin,        // Pin de-emphasis
  input  wire logic                    i_analog_mix_enable_pin,        // Pin mixing
  output logic                         o_bck,             // Bit clock out
  output logic                         o_bck_oe,          // Bit clock drive
  output logic                         o_word_select_clock,            // Word select out
  output logic                         o_word_select_clock_oe,         // Word select drive
  output adsfe_pkg::adsfe_sample_t     o_sample,          // Stereo pair
  output logic                         o_sample_valid,    // Pair strobe
  output adsfe_pkg::adsfe_cfg_t        o_cfg,             // Mode settings
  output logic [13:0]                  o_ramp_level,      // Ramp position
  output logic                         o_halted,          // Sync lost
  input  wire logic [3:0]              i_avs_address,     // Byte address
  input  wire logic                    i_avs_read,        // Read
  input  wire logic                    i_avs_write,       // Write
  input  wire logic [3:0]              i_avs_byteenable,  // Byte lanes
  input  wire logic [31:0]             i_avs_writedata,   // Write data
  output logic [31:0]                  o_avs_readdata,    // Read data
  output logic                         o_avs_waitrequest  // Wait
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int DW = $clog2(MBCK_HALF) + 1;
  localparam logic [HW-1:0] HOLD_END = HW'(HOLD_CYC);
  localparam logic [DW-1:0] DIV_END  = DW'(MBCK_HALF - 1);
  localparam logic [13:0]   RAMP_END = 14'(RAMP_FS);
  localparam int P_PD = 9, P_BCK = 8, P_LR = 7, P_SD = 6, P_CS = 5;
  localparam int P_CK = 4, P_CD = 3, P_FMT = 2, P_DEM = 1, P_MIX = 0;
  localparam logic [9:0] SYNC_RST = 10'h020;

  generate
    if (MBCK_HALF < `ADSFE_MBCK_CYC || HOLD_CYC < 1 || RAMP_FS < 2 || RAMP_FS > 16383) begin : g_chk
      $error("adsfe_top: parameter out of range");
    end
  endgenerate

  function automatic logic idx_ok(input logic [6:0] idx);
    idx_ok = idx >= `ADSFE_IDX_MIN && idx <= `ADSFE_IDX_MAX;
  endfunction : idx_ok

  function automatic adsfe_pkg::adsfe_fmt_t fmt_dec(input logic [2:0] f);
    if (f > `ADSFE_FMT_LJM) begin
      fmt_dec = adsfe_pkg::FMT_LJ;
    end else begin
      fmt_dec = adsfe_pkg::adsfe_fmt_t'(f);
    end
  endfunction : fmt_dec

  function automatic logic [23:0] align(input adsfe_pkg::adsfe_fmt_t f,
                                        input logic [23:0] lj, input logic [4:0] n,
                                        input logic [23:0] rj);
    case (f)
      adsfe_pkg::FMT_RJ24: align = rj;
      adsfe_pkg::FMT_RJ20: align = {rj[19:0], 4'h0};
      adsfe_pkg::FMT_RJ16: align = {rj[15:0], 8'h00};
      default:             align = lj << (5'(`ADSFE_LJ_BITS) - n);
    endcase
  endfunction : align

  logic [9:0]  pins;
  logic [9:0]  s1_r, s2_r, s3_r;
  logic [HW-1:0] hold_cnt_r;
  logic        pd_low, hold_act, soft_pd, dp_rst;
  logic [7:0]  mode_r [1:4];
  logic [31:0] mode_all;
  logic [15:0] cw_sr_r;
  logic [4:0]  cw_n_r;
  logic        ck_rise, cs_rise, commit;
  logic        pin_ctrl_r, master, i2s;
  adsfe_pkg::adsfe_fmt_t fmt;
  logic [DW-1:0] div_r;
  logic        mbck_r, mlr_r, mtick;
  logic [5:0]  mbit_r;
  logic        bck_rise, lr_lvl, lr_prv_r, lr_edge, fs_tick;
  logic [6:0]  bit_n_r;
  logic [23:0] lj_sr_r, rj_sr_r, word, left_r;
  logic [4:0]  lj_n_r;
  logic [7:0]  per_n_r, ref_n_r, dif;
  logic        seen_r, halted_r;
  adsfe_pkg::adsfe_pwr_t pwr_r;
  logic [13:0] level_r;
  logic        target_on, ack_r, req;

  assign pins = {i_pd_n, i_bck, i_word_select_clock, i_sdata, i_cs_n,
                 i_cclk, i_cdin, i_fmt_pin, i_deemphasis_pin_pin, i_analog_mix_enable_pin};

  // Two-stage synchronisers; stage three only feeds edge detection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign pd_low   = ~s2_r[P_PD];
  assign hold_act = hold_cnt_r != HOLD_END;
  assign soft_pd  = mode_r[4][`ADSFE_B_SOFT_POWER_DOWN_BIT];
  assign dp_rst   = hold_act | soft_pd; // see R1 see R2

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt_r <= '0;
    end else if (pd_low) begin
      hold_cnt_r <= '0;
    end else if (hold_act) begin
      hold_cnt_r <= hold_cnt_r + 1'b1; // see R4
    end
  end

  assign ck_rise = s2_r[P_CK] & ~s3_r[P_CK];
  assign cs_rise = s2_r[P_CS] & ~s3_r[P_CS];
  assign commit  = cs_rise && cw_n_r >= 5'(`ADSFE_CW_BITS) && !cw_sr_r[15]
                   && idx_ok(cw_sr_r[14:8]); // see R21 see R25

  // Control shifter; keeps the last 16 bits if the clock ran on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cw_sr_r <= '0;
      cw_n_r  <= '0;
    end else if (hold_act || s2_r[P_CS]) begin
      cw_n_r <= '0;
    end else if (ck_rise) begin
      cw_sr_r <= {cw_sr_r[14:0], s2_r[P_CD]}; // see R22 see R24
      if (cw_n_r != 5'h1F) begin
        cw_n_r <= cw_n_r + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r[1] <= `ADSFE_R1_RST;
      mode_r[2] <= `ADSFE_R2_RST;
      mode_r[3] <= `ADSFE_R3_RST;
      mode_r[4] <= `ADSFE_R4_RST;
    end else if (pd_low) begin
      mode_r[1] <= `ADSFE_R1_RST; // see R1 see R15
      mode_r[2] <= `ADSFE_R2_RST;
      mode_r[3] <= `ADSFE_R3_RST;
      mode_r[4] <= `ADSFE_R4_RST;
    end else if (commit) begin
      mode_r[cw_sr_r[10:8]] <= cw_sr_r[7:0]; // see R20 see R25
    end
  end

  assign mode_all = {mode_r[4], mode_r[3], mode_r[2], mode_r[1]};
  assign fmt = pin_ctrl_r ? (s2_r[P_FMT] ? adsfe_pkg::FMT_I2S : adsfe_pkg::FMT_LJ)
                          : fmt_dec(mode_r[3][2:0]); // see R9 see R18
  assign master = fmt == adsfe_pkg::FMT_LJM; // see R8
  assign i2s    = fmt == adsfe_pkg::FMT_I2S;

  // Master clocks: bit clock 64 fs, word select flips on bit clock fall
  assign mtick = div_r == DIV_END;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r  <= '0;
      mbck_r <= 1'b0;
      mbit_r <= '0;
      mlr_r  <= 1'b1;
    end else if (mtick) begin
      div_r  <= '0;
      mbck_r <= ~mbck_r;
      if (mbck_r) begin
        mbit_r <= mbit_r + 6'h01; // see R12
        mlr_r  <= ~mbit_r[5] ^ (mbit_r[4:0] == 5'(`ADSFE_MBCK_PER_HALF));
      end
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign o_bck     = mbck_r;
  assign o_word_select_clock    = mlr_r;
  assign o_bck_oe  = master; // see R8
  assign o_word_select_clock_oe = master;

  assign bck_rise = master ? (mtick & ~mbck_r) : (s2_r[P_BCK] & ~s3_r[P_BCK]); // see R6
  assign lr_lvl   = master ? mlr_r : s2_r[P_LR];
  assign lr_edge  = lr_lvl ^ lr_prv_r; // see R13
  assign fs_tick  = lr_edge & lr_lvl;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lr_prv_r <= 1'b0;
    end else begin
      lr_prv_r <= lr_lvl;
    end
  end

  // Shifters: left-justified keeps the first bits, right-justified the last
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_n_r <= '0;
      lj_n_r  <= '0;
      lj_sr_r <= '0;
      rj_sr_r <= '0;
    end else if (dp_rst || lr_edge) begin
      bit_n_r <= '0;
      lj_n_r  <= '0;
    end else if (bck_rise) begin
      if (bit_n_r != 7'h7F) begin
        bit_n_r <= bit_n_r + 7'h01;
      end
      rj_sr_r <= {rj_sr_r[22:0], s2_r[P_SD]}; // see R6 see R16
      if (lj_n_r < 5'(`ADSFE_LJ_BITS) && !(i2s && bit_n_r == 7'h00)) begin
        lj_sr_r <= {lj_sr_r[22:0], s2_r[P_SD]}; // see R16 see R17
        lj_n_r  <= lj_n_r + 5'h01;
      end
    end
  end

  assign word = align(fmt, lj_sr_r, lj_n_r, rj_sr_r); // see R17

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      left_r         <= '0;
      o_sample       <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= 1'b0;
      if (dp_rst) begin
        left_r   <= '0;
        o_sample <= '0;
      end else if (lr_edge && !halted_r) begin
        if (lr_prv_r ^ i2s) begin
          left_r <= word; // see R7
        end else begin
          o_sample       <= '{left: left_r, right: word}; // see R7
          o_sample_valid <= 1'b1;
        end
      end
    end
  end

  // Bit clocks per frame compared with the previous frame
  assign dif = per_n_r > ref_n_r ? per_n_r - ref_n_r : ref_n_r - per_n_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      per_n_r  <= '0;
      ref_n_r  <= '0;
      seen_r   <= 1'b0;
      halted_r <= 1'b0;
    end else if (dp_rst) begin
      per_n_r  <= '0;
      seen_r   <= 1'b0;
      halted_r <= 1'b0;
    end else if (fs_tick) begin
      per_n_r  <= '0;
      ref_n_r  <= per_n_r;
      seen_r   <= 1'b1;
      halted_r <= seen_r && dif > 8'(`ADSFE_DRIFT_BCK); // see R14
    end else if (bck_rise && per_n_r != 8'hFF) begin
      per_n_r <= per_n_r + 8'h01;
    end
  end

  assign o_halted = halted_r;

  // Output ramp; not cleared by power-down so the ramp down can run
  assign target_on = ~hold_act & ~soft_pd;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_r   <= adsfe_pkg::PWR_OFF;
      level_r <= '0;
    end else begin
      unique case (pwr_r)
        adsfe_pkg::PWR_OFF: begin
          if (target_on) begin
            pwr_r <= adsfe_pkg::PWR_UP; // see R3
          end
        end
        adsfe_pkg::PWR_UP: begin
          if (!target_on) begin
            pwr_r <= adsfe_pkg::PWR_DOWN;
          end else if (fs_tick) begin
            level_r <= level_r + 14'h0001; // see R5
            if (level_r + 14'h0001 == RAMP_END) begin
              pwr_r <= adsfe_pkg::PWR_ON;
            end
          end
        end
        adsfe_pkg::PWR_ON: begin
          if (!target_on) begin
            pwr_r <= adsfe_pkg::PWR_DOWN; // see R3
          end
        end
        adsfe_pkg::PWR_DOWN: begin
          if (target_on) begin
            pwr_r <= adsfe_pkg::PWR_UP;
          end else if (fs_tick) begin
            level_r <= level_r - 14'h0001; // see R5
            if (level_r == 14'h0001) begin
              pwr_r <= adsfe_pkg::PWR_OFF;
            end
          end
        end
      endcase
    end
  end

  assign o_ramp_level = level_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg <= '0;
    end else begin
      o_cfg.mutl   <= mode_r[1][6];
      o_cfg.mutr   <= mode_r[1][7];
      o_cfg.atl    <= mode_r[1][5:0];
      o_cfg.atr    <= mode_r[2][5:0];
      o_cfg.over   <= mode_r[3][7];
      o_cfg.rinv   <= mode_r[3][5];
      o_cfg.analog_mix_enable   <= pin_ctrl_r ? s2_r[P_MIX] : mode_r[3][4]; // see R19
      o_cfg.deemph <= pin_ctrl_r ? s2_r[P_DEM] : mode_r[3][3]; // see R19
      o_cfg.zcat   <= mode_r[4][4];
    end
  end

  // Avalon slave: one wait cycle, then the answer
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r          <= 1'b0;
      o_avs_readdata <= '0;
      pin_ctrl_r     <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
      if (i_avs_read && !ack_r) begin
        case (i_avs_address)
          `ADSFE_A_STATUS: o_avs_readdata <= {27'h0, pwr_r, halted_r, master, hold_act};
          `ADSFE_A_MODE:   o_avs_readdata <= mode_all;
          `ADSFE_A_CTRL:   o_avs_readdata <= {31'h0, pin_ctrl_r};
          `ADSFE_A_RAMP:   o_avs_readdata <= {18'h0, level_r};
          default:         o_avs_readdata <= '0;
        endcase
      end
      if (i_avs_write && ack_r && i_avs_address == `ADSFE_A_CTRL && i_avs_byteenable[0]) begin
        pin_ctrl_r <= i_avs_writedata[0];
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  hold_rel_a: assert property ($fell(hold_act) |-> // see R4
    $past(s2_r[P_PD], HOLD_CYC) && !$past(s2_r[P_PD], HOLD_CYC + 1))
    else $error("hold release not at 1024 clocks");
  pin_clr_a: assert property (pd_low |=> mode_all == 32'h00003F3F && hold_act) // see R1
    else $error("pin power-down did not clear modes");
  soft_keep_a: assert property (soft_pd && !pd_low && !commit |=> $stable(mode_all)) // see R2
    else $error("soft power-down changed modes");
  ramp_top_a: assert property (pwr_r == adsfe_pkg::PWR_UP && fs_tick && target_on // see R5
    && level_r == RAMP_END - 14'h0001 |=> pwr_r == adsfe_pkg::PWR_ON && level_r == RAMP_END)
    else $error("ramp end wrong");
  ramp_dn_a: assert property (pwr_r == adsfe_pkg::PWR_ON && !target_on // see R3
    |=> pwr_r == adsfe_pkg::PWR_DOWN ##1 (level_r == RAMP_END)[*2])
    else $error("ramp down not started");
  mlr_half_a: assert property (master && mtick && mbck_r && mbit_r == 6'h1F // see R12
    |=> !mlr_r && !mbck_r)
    else $error("master word select off");
  clk_dir_a: assert property (o_bck_oe |-> o_word_select_clock_oe && fmt == adsfe_pkg::FMT_LJM) // see R8
    else $error("clock direction wrong");
  commit_a: assert property (commit |=> // see R25
    mode_r[$past(cw_sr_r[10:8])] == $past(cw_sr_r[7:0]) || $past(pd_low))
    else $error("control write lost");
  short_a: assert property (cs_rise && cw_n_r < 5'h10 && !pd_low |=> $stable(mode_all)) // see R25
    else $error("short frame written");
  halt_hold_a: assert property (halted_r && !dp_rst |=> $stable(o_sample)) // see R14
    else $error("output moved while halted");
  pair_a: assert property (o_sample_valid |-> $past(lr_edge) && !$past(halted_r)) // see R7
    else $error("pair outside word edge");

  cmt_c: cover property (commit);
  i2s_c: cover property (i2s && o_sample_valid);
  on_c: cover property (pwr_r == adsfe_pkg::PWR_ON);
  halt_c: cover property ($rose(halted_r));
endmodule : adsfe_top

// >>> inc/adsfe_consts.svh
`ifndef ADSFE_CONSTS_SVH
`define ADSFE_CONSTS_SVH
`define ADSFE_CLK_NS 40
`define ADSFE_HOLD_CYC 1024
`define ADSFE_RAMP_FS 9334
`define ADSFE_DRIFT_BCK 3
`define ADSFE_MBCK_MIN_NS 146
`define ADSFE_MBCK_CYC ((`ADSFE_MBCK_MIN_NS + `ADSFE_CLK_NS - 1) / `ADSFE_CLK_NS)
`define ADSFE_MBCK_PER_HALF 31
`define ADSFE_CW_BITS 16
`define ADSFE_LJ_BITS 24
`define ADSFE_IDX_MIN 7'h01
`define ADSFE_IDX_MAX 7'h04
`define ADSFE_R1_RST 8'h3F
`define ADSFE_R2_RST 8'h3F
`define ADSFE_R3_RST 8'h00
`define ADSFE_R4_RST 8'h00
`define ADSFE_B_SOFT_POWER_DOWN_BIT 0
`define ADSFE_A_STATUS 4'h0
`define ADSFE_A_MODE 4'h4
`define ADSFE_A_CTRL 4'h8
`define ADSFE_A_RAMP 4'hC
`define ADSFE_FMT_LJ 3'h0
`define ADSFE_FMT_I2S 3'h1
`define ADSFE_FMT_RJ24 3'h2
`define ADSFE_FMT_RJ20 3'h3
`define ADSFE_FMT_RJ16 3'h4
`define ADSFE_FMT_LJM 3'h5
`endif

// >>> inc/adsfe_pkg.sv
`include "adsfe_consts.svh"
package adsfe_pkg;
  typedef enum logic [2:0] {
    FMT_LJ   = `ADSFE_FMT_LJ,
    FMT_I2S  = `ADSFE_FMT_I2S,
    FMT_RJ24 = `ADSFE_FMT_RJ24,
    FMT_RJ20 = `ADSFE_FMT_RJ20,
    FMT_RJ16 = `ADSFE_FMT_RJ16,
    FMT_LJM  = `ADSFE_FMT_LJM
  } adsfe_fmt_t;
  typedef enum logic [1:0] {PWR_OFF, PWR_UP, PWR_ON, PWR_DOWN} adsfe_pwr_t;
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } adsfe_sample_t;
  typedef struct packed {
    logic       mutl;
    logic       mutr;
    logic [5:0] atl;
    logic [5:0] atr;
    logic       over;
    logic       rinv;
    logic       analog_mix_enable;
    logic       deemph;
    logic       zcat;
  } adsfe_cfg_t;
endpackage : adsfe_pkg
